// >>> logic/tmu_defines.vh
// Purpose: constants for the two-family timer unit
// Assumes: byte addresses on a 32-bit apb bus
// Notes:   definitions only
`ifndef TMU_DEFINES_VH
`define TMU_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TMU_ADDR_CTRL      8'h00
`define TMU_ADDR_TA        8'h04
`define TMU_ADDR_TB        8'h08
`define TMU_ADDR_IRQ_STAT  8'h0C
`define TMU_ADDR_IRQ_MASK  8'h10
`define TMU_ADDR_STATUS    8'h14

// ----------------------------------------
// control register fields
// ----------------------------------------
`define TMU_CTRL_START_A   0
`define TMU_CTRL_START_B   1
`define TMU_CTRL_MODE_A_LO 2
`define TMU_CTRL_MODE_B_LO 4
`define TMU_CTRL_UP_A      6
`define TMU_CTRL_FREE_A    7
`define TMU_CTRL_MEAS_B    8
`define TMU_CTRL_WIDTH     9
`define TMU_CTRL_RESET     9'h000

// ----------------------------------------
// modes
// ----------------------------------------
`define TMU_MODE_TIMER     2'h0
`define TMU_MODE_EVENT     2'h1
`define TMU_MODE_ONESHOT   2'h2
`define TMU_MODE_PWM       2'h3
`define TMU_MODE_MEASURE   2'h2

// ----------------------------------------
// misc
// ----------------------------------------
`define TMU_CNT_WIDTH      16
`define TMU_TICK_DIV       4
`define TMU_IRQ_BITS       2

`endif

// >>> logic/tmu_timer_a.v
// Purpose: first timer family: timer, event, one-shot and pwm modes
// Assumes: tick and evtEdge are one-cycle enables on core_clk
// Notes:   reload moment lasts one cycle showing the wrapped value
`timescale 1ns/10ps
`include "tmu_defines.vh"
module tmu_timer_a #(
  parameter W = `TMU_CNT_WIDTH
) (
  input  wire         core_clk,
  input  wire         reset_n,
  input  wire         tick,
  input  wire         evtEdge,
  input  wire         start,
  input  wire [1:0]   mode,
  input  wire         upCount,
  input  wire         freeRun,
  input  wire         wrEn,
  input  wire [W-1:0] wrData,
  output wire [W-1:0] count,
  output wire         running,
  output reg          timer_pulse_output_pin,
  output reg          irqPulse
);
  reg [W-1:0] cnt_q, cnt_d, reload_q, reload_d;
  reg         pend_q, pend_d, run_q, run_d, out_d, irq_d;
  reg         startPrev_q;
  reg [1:0]   modePrev_q;
  wire        startRise = start & ~startPrev_q;
  wire        startFall = ~start & startPrev_q;
  wire        stepEn    = (mode == `TMU_MODE_EVENT) ? evtEdge : tick;
  wire        goUp      = (mode == `TMU_MODE_EVENT) & upCount;
  wire        modeIrq   = (mode != modePrev_q) &&
                          (mode == `TMU_MODE_ONESHOT || mode == `TMU_MODE_PWM) &&
                          (modePrev_q == `TMU_MODE_TIMER || modePrev_q == `TMU_MODE_EVENT);

  assign count   = cnt_q;   // live value, wrapped value at reload moment
  assign running = run_q;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always @* begin
    cnt_d    = cnt_q;
    reload_d = wrEn ? wrData : reload_q;
    pend_d   = 1'b0;
    run_d    = run_q;
    out_d    = timer_pulse_output_pin;
    irq_d    = modeIrq;                         // mode selection flags
    case (mode)
      `TMU_MODE_ONESHOT: begin
        if (startRise) begin
          run_d = 1'b1;
          cnt_d = reload_q;
          out_d = 1'b1;
        end else if (run_q && startFall) begin
          run_d = 1'b0;
          cnt_d = reload_q;                     // stop and reload
          out_d = 1'b0;                         // output low
          irq_d = 1'b1;                         // request on abort
        end else if (run_q && tick) begin
          if (cnt_q == {W{1'b0}}) begin
            run_d = 1'b0;
            out_d = 1'b0;
            irq_d = 1'b1;
            cnt_d = reload_q;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
      end
      `TMU_MODE_PWM: begin
        if (startRise) begin
          run_d = 1'b1;
          cnt_d = reload_q;
          out_d = 1'b1;
        end else if (run_q && startFall) begin
          run_d = 1'b0;                         // counter stops
          out_d = 1'b0;                         // low stays low, high goes low
          irq_d = irq_d | timer_pulse_output_pin; // request only if it was high
        end else if (run_q && tick) begin
          if (cnt_q == {W{1'b0}}) begin
            out_d = ~timer_pulse_output_pin;
            cnt_d = timer_pulse_output_pin ? ~reload_q : reload_q;
            irq_d = irq_d | timer_pulse_output_pin;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
      end
      default: begin
        run_d = start;
        out_d = 1'b0;
        if (!start) begin
          if (wrEn)
            cnt_d = wrData;                     // halted write reads back
        end else if (pend_q) begin
          cnt_d = reload_q;
        end else if (stepEn) begin
          if (goUp) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == {W{1'b1}}) begin
              irq_d  = 1'b1;
              pend_d = ~freeRun;                // zero shown at reload moment
            end
          end else begin
            cnt_d = cnt_q - 1'b1;
            if (cnt_q == {W{1'b0}}) begin
              irq_d  = 1'b1;
              pend_d = ~(freeRun && mode == `TMU_MODE_EVENT); // all ones shown
            end
          end
        end
      end
    endcase
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      cnt_q                  <= {W{1'b0}};
      reload_q               <= {W{1'b0}};
      pend_q                 <= 1'b0;
      run_q                  <= 1'b0;
      timer_pulse_output_pin <= 1'b0;
      irqPulse               <= 1'b0;
      startPrev_q            <= 1'b0;
      modePrev_q             <= `TMU_MODE_TIMER;
    end else begin
      cnt_q                  <= cnt_d;
      reload_q               <= reload_d;
      pend_q                 <= pend_d;
      run_q                  <= run_d;
      timer_pulse_output_pin <= out_d;
      irqPulse               <= irq_d;
      startPrev_q            <= start;
      modePrev_q             <= mode;
    end
  end
endmodule // tmu_timer_a

// >>> logic/tmu_timer_b.v
// Purpose: second timer family: timer, event and period/width measurement
// Assumes: tick, evtRise, evtFall are one-cycle enables on core_clk
// Notes:   measurement read returns the captured reload register
`timescale 1ns/10ps
`include "tmu_defines.vh"
module tmu_timer_b #(
  parameter W = `TMU_CNT_WIDTH
) (
  input  wire         core_clk,
  input  wire         reset_n,
  input  wire         tick,
  input  wire         evtRise,
  input  wire         evtFall,
  input  wire         start,
  input  wire [1:0]   mode,
  input  wire         measSel,
  input  wire         wrEn,
  input  wire [W-1:0] wrData,
  output wire [W-1:0] readValue,
  output wire         running,
  output reg          irqPulse
);
  reg [W-1:0] cnt_q, cnt_d, reload_q, reload_d;
  reg         pend_q, pend_d, first_q, first_d, irq_d, startPrev_q, measPrev_q;
  wire        isMeas  = mode[1];
  wire        stepEn  = (mode == `TMU_MODE_EVENT) ? evtRise : tick;
  wire        effEdge = measSel ? (evtRise | evtFall) : evtRise;

  assign readValue = isMeas ? reload_q : cnt_q;  // captured value in measurement mode, else live count
  assign running   = start;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always @* begin
    cnt_d    = cnt_q;
    reload_d = reload_q;
    pend_d   = 1'b0;
    first_d  = first_q;
    irq_d    = 1'b0;
    if (isMeas) begin
      if (start && !startPrev_q) begin
        cnt_d   = {W{1'b0}};
        first_d = 1'b1;
      end else if (start) begin
        if (measSel != measPrev_q)
          irq_d = 1'b1;                         // select change while counting
        if (effEdge) begin
          reload_d = cnt_q;                     // first capture meaningless
          cnt_d    = {W{1'b0}};
          first_d  = 1'b0;
          irq_d    = irq_d | ~first_q;          // no request on first edge
        end else if (tick) begin
          cnt_d = cnt_q + 1'b1;
        end
      end
    end else begin
      if (wrEn)
        reload_d = wrData;
      if (!start) begin
        if (wrEn)
          cnt_d = wrData;                       // halted write reads back
      end else if (pend_q) begin
        cnt_d = reload_q;
      end else if (stepEn) begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == {W{1'b0}}) begin
          irq_d  = 1'b1;
          pend_d = 1'b1;                        // all ones shown at reload moment
        end
      end
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      cnt_q       <= {W{1'b0}};
      reload_q    <= {W{1'b0}};
      pend_q      <= 1'b0;
      first_q     <= 1'b0;
      irqPulse    <= 1'b0;
      startPrev_q <= 1'b0;
      measPrev_q  <= 1'b0;
    end else begin
      cnt_q       <= cnt_d;
      reload_q    <= reload_d;
      pend_q      <= pend_d;
      first_q     <= first_d;
      irqPulse    <= irq_d;
      startPrev_q <= start;
      measPrev_q  <= measSel;
    end
  end
endmodule // tmu_timer_b

// >>> logic/tmu_top.v
// Purpose: apb-facing timer unit with two timer families and one interrupt
// Assumes: pins synchronous to core_clk; zero-wait apb slave
// Notes:   read data is captured in the setup cycle
`timescale 1ns/10ps
`include "tmu_defines.vh"
module tmu_top #(
  parameter W        = `TMU_CNT_WIDTH,
  parameter TICK_DIV = `TMU_TICK_DIV
) (
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        eventPinA,
  input  wire        eventPinB,
  output wire        timer_pulse_output_pin,
  output reg         irq
);
  reg [`TMU_CTRL_WIDTH-1:0] ctrl_q;
  reg [`TMU_IRQ_BITS-1:0]   irqStat_q, irqStat_d, irqMask_q;
  reg [7:0]                 div_q;
  reg                       tick_q, pinA_q, pinB_q;
  wire [W-1:0]              countA, valueB;
  wire                      runA, runB, irqA, irqB;
  wire                      wrDone = psel & penable & pready & pwrite;

  // address decode, used by read and write paths
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `TMU_ADDR_CTRL) || (a == `TMU_ADDR_TA) || (a == `TMU_ADDR_TB) ||
               (a == `TMU_ADDR_IRQ_STAT) || (a == `TMU_ADDR_IRQ_MASK) || (a == `TMU_ADDR_STATUS);
    end
  endfunction

  wire wrCtrl = wrDone && paddr == `TMU_ADDR_CTRL;
  wire wrTa   = wrDone && paddr == `TMU_ADDR_TA;
  wire wrTb   = wrDone && paddr == `TMU_ADDR_TB;
  wire wrStat = wrDone && paddr == `TMU_ADDR_IRQ_STAT;
  wire wrMask = wrDone && paddr == `TMU_ADDR_IRQ_MASK;

  // ----------------------------------------
  // prescaler and pin edge detect
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      div_q  <= 8'h00;
      tick_q <= 1'b0;
      pinA_q <= 1'b0;
      pinB_q <= 1'b0;
    end else begin
      tick_q <= (div_q == TICK_DIV[7:0] - 8'h01);
      div_q  <= (div_q == TICK_DIV[7:0] - 8'h01) ? 8'h00 : div_q + 8'h01;
      pinA_q <= eventPinA;
      pinB_q <= eventPinB;
    end
  end

  // ----------------------------------------
  // timer instances
  // ----------------------------------------
  tmu_timer_a #(.W(W)) uTimerA (
    .core_clk               (core_clk),
    .reset_n                (reset_n),
    .tick                   (tick_q),
    .evtEdge                (eventPinA & ~pinA_q),
    .start                  (ctrl_q[`TMU_CTRL_START_A]),
    .mode                   (ctrl_q[`TMU_CTRL_MODE_A_LO+1:`TMU_CTRL_MODE_A_LO]),
    .upCount                (ctrl_q[`TMU_CTRL_UP_A]),
    .freeRun                (ctrl_q[`TMU_CTRL_FREE_A]),
    .wrEn                   (wrTa),
    .wrData                 (pwdata[W-1:0]),
    .count                  (countA),
    .running                (runA),
    .timer_pulse_output_pin (timer_pulse_output_pin),
    .irqPulse               (irqA)
  );

  tmu_timer_b #(.W(W)) uTimerB (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .tick      (tick_q),
    .evtRise   (eventPinB & ~pinB_q),
    .evtFall   (~eventPinB & pinB_q),
    .start     (ctrl_q[`TMU_CTRL_START_B]),
    .mode      (ctrl_q[`TMU_CTRL_MODE_B_LO+1:`TMU_CTRL_MODE_B_LO]),
    .measSel   (ctrl_q[`TMU_CTRL_MEAS_B]),
    .wrEn      (wrTb),
    .wrData    (pwdata[W-1:0]),
    .readValue (valueB),
    .running   (runB),
    .irqPulse  (irqB)
  );

  // ----------------------------------------
  // sticky status, set wins over write-one clear
  // ----------------------------------------
  always @* begin
    irqStat_d = irqStat_q & ~(wrStat ? pwdata[`TMU_IRQ_BITS-1:0] : {`TMU_IRQ_BITS{1'b0}});
    irqStat_d = irqStat_d | {irqB, irqA};       // request bits
  end

  // ----------------------------------------
  // registers and interrupt line
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl_q    <= `TMU_CTRL_RESET;
      irqStat_q <= {`TMU_IRQ_BITS{1'b0}};
      irqMask_q <= {`TMU_IRQ_BITS{1'b0}};
      irq       <= 1'b0;
    end else begin
      if (wrCtrl)
        ctrl_q <= pwdata[`TMU_CTRL_WIDTH-1:0];
      if (wrMask)
        irqMask_q <= pwdata[`TMU_IRQ_BITS-1:0];
      irqStat_q <= irqStat_d;
      irq       <= |(irqStat_q & irqMask_q);
    end
  end

  // ----------------------------------------
  // apb answer: ready in first access cycle
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `TMU_ADDR_CTRL:     prdata <= {{(32-`TMU_CTRL_WIDTH){1'b0}}, ctrl_q};
          `TMU_ADDR_TA:       prdata <= {{(32-W){1'b0}}, countA};
          `TMU_ADDR_TB:       prdata <= {{(32-W){1'b0}}, valueB};
          `TMU_ADDR_IRQ_STAT: prdata <= {{(32-`TMU_IRQ_BITS){1'b0}}, irqStat_q};
          `TMU_ADDR_IRQ_MASK: prdata <= {{(32-`TMU_IRQ_BITS){1'b0}}, irqMask_q};
          `TMU_ADDR_STATUS:   prdata <= {29'h00000000, runB, runA, timer_pulse_output_pin};
          default:            prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // tmu_top

// >>> testbench/tmu_top_assertions.sv
// Purpose: port-level checks of the timer unit
// Assumes: apb master holds each request until pready
// Notes:   bound to tmu_top at the foot of this file
`timescale 1ns/10ps
`include "tmu_defines.vh"
module tmu_assertions (
  input wire        core_clk,
  input wire        reset_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        timer_pulse_output_pin,
  input wire        irq
);
  wire mapped;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // -----------------------------------------
  // apb timing and decode
  // -----------------------------------------
  // address decode of the six registers
  assign mapped = paddr inside {`TMU_ADDR_CTRL, `TMU_ADDR_TA, `TMU_ADDR_TB,
                                `TMU_ADDR_IRQ_STAT, `TMU_ADDR_IRQ_MASK, `TMU_ADDR_STATUS};
  property p_ready_after_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready late");
  property p_ready_in_access;
    pready |-> psel && penable;
  endproperty
  a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
  property p_ready_single;
    pready |=> !pready;
  endproperty
  a_ready_single: assert property (p_ready_single) else $error("pready too long");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
  property p_unmapped_err;
    psel && penable && pready |-> pslverr == !mapped;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("wrong pslverr");
  property p_read_narrow;
    pready && !pwrite |-> prdata[31:16] == 16'h0000 && (mapped || prdata == 32'h0);
  endproperty
  a_read_narrow: assert property (p_read_narrow) else $error("read data upper bits set");
  property p_prdata_hold;
    !psel |=> $stable(prdata);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold) else $error("prdata moved while idle");
  // -----------------------------------------
  // reset and interrupt
  // -----------------------------------------
  property p_reset_vals;
    $rose(reset_n) |-> prdata == 32'h0 && !pready && !pslverr && !irq && !timer_pulse_output_pin;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("outputs not cleared by reset");
  property p_mask_off;
    psel && penable && pready && pwrite && paddr == `TMU_ADDR_IRQ_MASK && pwdata[1:0] == 2'h0
      |-> ##2 !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq despite zero mask");
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_pin: cover property ($fell(timer_pulse_output_pin));
endmodule // tmu_assertions

bind tmu_top tmu_assertions u_chk (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_pulse_output_pin(timer_pulse_output_pin), .irq(irq));

// >>> testbench/tmu_pin_model.sv
// Purpose: external event source on both timer pins
// Assumes: pins synchronous to core_clk
// Notes:   a stopped pin holds its level
`timescale 1ns/10ps
module tmu_pin_model #(
  parameter HALF = 6
) (
  input  wire  core_clk,
  input  wire  runA,
  input  wire  runB,
  output logic eventPinA,
  output logic eventPinB
);
  int cnt;

  initial begin
    cnt = 0;
    eventPinA = 1'b0;
    eventPinB = 1'b0;
  end
  // toggle enabled pins every HALF cycles
  always @(posedge core_clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      if (runA) eventPinA <= ~eventPinA;
      if (runB) eventPinB <= ~eventPinB;
    end
  end
endmodule // tmu_pin_model

// >>> testbench/tb.sv
// Purpose: self-checking bench of the timer unit
// Assumes: zero-wait apb slave, TICK_DIV of 2
// Notes:   random reload values from a fixed seed
`timescale 1ns/10ps
`include "tmu_defines.vh"
module tb;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        runA     = 1'b0;
  logic        runB     = 1'b0;
  wire  [31:0] prdata;
  wire         pready, pslverr, pinOut, irq, eventPinA, eventPinB;
  logic [31:0] rd, r1;
  logic        err;
  int          failures = 0;
  int          checks   = 0;
  int          seed     = 32'hEE555A8A;

  always #2.5 core_clk = ~core_clk;

  tmu_top #(.W(16), .TICK_DIV(2)) dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eventPinA(eventPinA), .eventPinB(eventPinB), .timer_pulse_output_pin(pinOut), .irq(irq));
  tmu_pin_model #(.HALF(6)) pins (.core_clk(core_clk), .runA(runA), .runB(runB), .eventPinA(eventPinA),
    .eventPinB(eventPinB));

  // -----------------------------------------
  // helpers
  // -----------------------------------------
  // control word from fields
  function automatic logic [31:0] ctrl(input logic sa, input logic [1:0] ma, input logic sb,
                                       input logic [1:0] mb, input logic ms);
    ctrl = 32'h0;
    ctrl[`TMU_CTRL_START_A] = sa;
    ctrl[`TMU_CTRL_START_B] = sb;
    ctrl[`TMU_CTRL_MODE_A_LO +: 2] = ma;
    ctrl[`TMU_CTRL_MODE_B_LO +: 2] = mb;
    ctrl[`TMU_CTRL_MEAS_B] = ms;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, exp, rd);
  endtask
  // run a counter and sample it at random moments
  task automatic probe(input string name, input logic [7:0] a, input logic [31:0] c,
                       input logic [15:0] rl, input logic [15:0] wrapv);
    int hits, bad;
    hits = 0; bad = 0;
    apb(1'b1, `TMU_ADDR_CTRL, c & ~32'h3);
    apb(1'b1, a, {16'h0, rl});
    apb(1'b1, `TMU_ADDR_CTRL, c);
    runA <= 1'b1; runB <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      cyc($unsigned($random(seed)) % 3);
      apb(1'b0, a, 32'h0);
      if (rd[15:0] === wrapv) hits++;
      else if (rd[15:0] !== rl) bad++;
    end
    apb(1'b1, `TMU_ADDR_CTRL, c & ~32'h3);
    runA <= 1'b0; runB <= 1'b0;
    check({name, " wrap seen"}, 32'h1, {31'h0, hits > 0});
    check({name, " strays"}, 32'h0, bad);
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // -----------------------------------------
  // scenarios
  // -----------------------------------------
  initial begin
    logic [15:0] v;
    cyc(10);
    reset_n <= 1'b1;
    rdchk("ctrl reset", `TMU_ADDR_CTRL, 32'h0);
    rdchk("stat reset", `TMU_ADDR_IRQ_STAT, 32'h0);
    check("irq reset", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h18, 32'hFFFFFFFF);
    check("wr unmapped err", 32'h1, {31'h0, err});
    apb(1'b0, 8'h18, 32'h0);
    check("rd unmapped err", 32'h1, {31'h0, err});
    check("rd unmapped", 32'h0, rd);
    $display("test reset and decode done");
    // halted write and read back, corners then random
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : $random(seed);
      apb(1'b1, `TMU_ADDR_TA, {16'h0, v});
      rdchk("ta readback", `TMU_ADDR_TA, {16'h0, v});
      apb(1'b1, `TMU_ADDR_TB, {16'h0, ~v});
      rdchk("tb readback", `TMU_ADDR_TB, {16'h0, ~v});
    end
    $display("test readback done");
    // mode changes from timer and event into one-shot and pwm
    apb(1'b1, `TMU_ADDR_IRQ_MASK, 32'h1);
    rdchk("mask readback", `TMU_ADDR_IRQ_MASK, 32'h1);
    for (int f = 0; f < 2; f++) begin
      for (int t = 2; t < 4; t++) begin
        apb(1'b1, `TMU_ADDR_CTRL, ctrl(1'b0, f[1:0], 1'b0, 2'h0, 1'b0));
        apb(1'b1, `TMU_ADDR_IRQ_STAT, 32'h3);
        cyc(3);
        check("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, `TMU_ADDR_CTRL, ctrl(1'b0, t[1:0], 1'b0, 2'h0, 1'b0));
        cyc(4);
        rdchk("mode request", `TMU_ADDR_IRQ_STAT, 32'h1);
        check("irq raised", 32'h1, {31'h0, irq});
      end
    end
    apb(1'b1, `TMU_ADDR_IRQ_MASK, 32'h0);
    cyc(3);
    check("irq masked", 32'h0, {31'h0, irq});
    $display("test mode requests done");
    // one-shot stopped in mid-count
    apb(1'b1, `TMU_ADDR_CTRL, ctrl(1'b0, `TMU_MODE_ONESHOT, 1'b0, 2'h0, 1'b0));
    apb(1'b1, `TMU_ADDR_TA, 32'h0100);
    apb(1'b1, `TMU_ADDR_IRQ_STAT, 32'h3);
    apb(1'b1, `TMU_ADDR_CTRL, ctrl(1'b1, `TMU_MODE_ONESHOT, 1'b0, 2'h0, 1'b0));
    cyc(6);
    apb(1'b0, `TMU_ADDR_TA, 32'h0);
    r1 = rd;
    cyc(8);
    apb(1'b0, `TMU_ADDR_TA, 32'h0);
    check("ta live", 32'h1, {31'h0, rd < r1 && r1 < 32'h0100});
    check("pin high", 32'h1, {31'h0, pinOut});
    rdchk("status running", `TMU_ADDR_STATUS, 32'h3);
    apb(1'b1, `TMU_ADDR_CTRL, ctrl(1'b0, `TMU_MODE_ONESHOT, 1'b0, 2'h0, 1'b0));
    cyc(4);
    check("pin low", 32'h0, {31'h0, pinOut});
    rdchk("status stopped", `TMU_ADDR_STATUS, 32'h0);
    rdchk("oneshot request", `TMU_ADDR_IRQ_STAT, 32'h1);
    rdchk("ta reloaded", `TMU_ADDR_TA, 32'h0100);
    $display("test one-shot stop done");
    // pwm stopped while high, then while low
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `TMU_ADDR_CTRL, ctrl(1'b0, `TMU_MODE_PWM, 1'b0, 2'h0, 1'b0));
      apb(1'b1, `TMU_ADDR_TA, k ? 32'h0000 : 32'h0200);
      apb(1'b1, `TMU_ADDR_CTRL, ctrl(1'b1, `TMU_MODE_PWM, 1'b0, 2'h0, 1'b0));
      cyc(12);
      apb(1'b1, `TMU_ADDR_IRQ_STAT, 32'h3);
      check("pwm level", {31'h0, !k}, {31'h0, pinOut});
      apb(1'b1, `TMU_ADDR_CTRL, ctrl(1'b0, `TMU_MODE_PWM, 1'b0, 2'h0, 1'b0));
      cyc(4);
      check("pwm stop pin", 32'h0, {31'h0, pinOut});
      rdchk("pwm stop request", `TMU_ADDR_IRQ_STAT, {31'h0, !k});
    end
    $display("test pwm stop done");
    probe("ta timer", `TMU_ADDR_TA, ctrl(1'b1, `TMU_MODE_TIMER, 1'b0, 2'h0, 1'b0), 16'h0000, 16'hFFFF);
    probe("ta down", `TMU_ADDR_TA, ctrl(1'b1, `TMU_MODE_EVENT, 1'b0, 2'h0, 1'b0), 16'h0000, 16'hFFFF);
    probe("ta up", `TMU_ADDR_TA, ctrl(1'b1, `TMU_MODE_EVENT, 1'b0, 2'h0, 1'b0) | 32'h1 << `TMU_CTRL_UP_A,
          16'hFFFF, 16'h0000);
    probe("tb timer", `TMU_ADDR_TB, ctrl(1'b0, 2'h0, 1'b1, `TMU_MODE_TIMER, 1'b0), 16'h0000, 16'hFFFF);
    probe("tb event", `TMU_ADDR_TB, ctrl(1'b0, 2'h0, 1'b1, `TMU_MODE_EVENT, 1'b0), 16'h0000, 16'hFFFF);
    $display("test reload moment done");
    // measurement select flipped while counting
    apb(1'b1, `TMU_ADDR_CTRL, ctrl(1'b0, 2'h0, 1'b1, `TMU_MODE_MEASURE, 1'b0));
    cyc(2);
    apb(1'b1, `TMU_ADDR_IRQ_STAT, 32'h3);
    apb(1'b1, `TMU_ADDR_CTRL, ctrl(1'b0, 2'h0, 1'b1, `TMU_MODE_MEASURE, 1'b1));
    cyc(4);
    rdchk("measure select request", `TMU_ADDR_IRQ_STAT, 32'h2);
    // first edge after start gives no request, second does
    apb(1'b1, `TMU_ADDR_CTRL, ctrl(1'b0, 2'h0, 1'b0, `TMU_MODE_MEASURE, 1'b0));
    apb(1'b1, `TMU_ADDR_CTRL, ctrl(1'b0, 2'h0, 1'b1, `TMU_MODE_MEASURE, 1'b0));
    apb(1'b1, `TMU_ADDR_IRQ_STAT, 32'h3);
    runB <= 1'b1;
    @(posedge eventPinB);
    cyc(3);
    rdchk("first edge quiet", `TMU_ADDR_IRQ_STAT, 32'h0);
    @(posedge eventPinB);
    cyc(5);
    rdchk("second edge request", `TMU_ADDR_IRQ_STAT, 32'h2);
    runB <= 1'b0;
    $display("test measurement done");
    end_of_test();
  end

  // hang guard, far beyond the two thousand or so cycles needed
  initial begin
    #100000;
    failures++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule // tb
